// File: sim/dmem_model.sv
// Far-side data memory and priority logic model
`timescale 1ns/10ps
`default_nettype none
module dmem_model (
  input  wire logic       clock,
  input  wire logic       dwr_valid,
  input  wire logic [7:0] dwr_addr,
  input  wire logic [7:0] dwr_data,
  input  wire logic       prio_release,
  input  wire logic [7:0] probe_addr,
  output wire logic [7:0] probe_data,
  output var  logic [3:0] release_count
);
  logic [7:0] mem [0:255];
  initial release_count = 4'h0;
  always @(posedge clock) begin
    if (dwr_valid)
      mem[dwr_addr] <= dwr_data;
    if (prio_release)
      release_count <= release_count + 4'h1;
  end
  assign probe_data = mem[probe_addr];
endmodule
`default_nettype wire

// File: sim/or_stack_rotate_chk.sv
// Port assertions for the OR, stack and rotate execution unit
`timescale 1ns/10ps
`default_nettype none
`include "or_stack_rotate_map.vh"
module or_stack_rotate_chk (
  input wire logic             clock,
  input wire logic             rst_b,
  input wire logic             op_valid,
  input wire logic [`OP_W-1:0] op_code,
  input wire logic             src_bit,
  input wire logic             op_ready,
  input wire logic [7:0]       accumulator_reg,
  input wire logic             carry_r,
  input wire logic [7:0]       stack_pointer,
  input wire logic             pc_load_r,
  input wire logic             prio_release_r,
  input wire logic             done_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire go = op_valid && op_ready;
  or_done_a: assert property (go && op_code == `OP_OR_BYTE |=> done_r)
    else $error("byte OR did not complete in one cycle");
  rot_left_a: assert property (go && op_code == `OP_RL |=> $stable(carry_r) &&
    accumulator_reg == {$past(accumulator_reg[6:0]), $past(accumulator_reg[7])})
    else $error("rotate left result wrong");
  rlc_ring_a: assert property (go && op_code == `OP_RLC |=>
    carry_r == $past(accumulator_reg[7]) &&
    accumulator_reg == {$past(accumulator_reg[6:0]), $past(carry_r)})
    else $error("rotate left through carry wrong");
  rrc_ring_a: assert property (go && op_code == `OP_RRC |=>
    carry_r == $past(accumulator_reg[0]) &&
    accumulator_reg == {$past(carry_r), $past(accumulator_reg[7:1])})
    else $error("rotate right through carry wrong");
  carry_set_a: assert property (go && op_code == `OP_OR_CARRY && src_bit |=> carry_r)
    else $error("bit OR did not set carry");
  carry_inv_a: assert property (go && op_code == `OP_OR_CARRY_INV && !src_bit |=> carry_r)
    else $error("inverted bit OR did not set carry");
  push_inc_a: assert property (go && op_code == `OP_PUSH |=>
    stack_pointer == $past(stack_pointer) + 8'h01 && !op_ready ##1 done_r)
    else $error("push pointer step wrong");
  interrupt_return_op_pop_a: assert property (go && op_code == `OP_INTERRUPT_RETURN_OP |-> ##4 done_r && pc_load_r &&
    prio_release_r && stack_pointer == $past(stack_pointer, 4) - 8'h02)
    else $error("interrupt return sequence wrong");
  cover property (go && op_code == `OP_INTERRUPT_RETURN_OP);
  cover property (go && op_code == `OP_POP);
  cover property (go && op_code == `OP_RRC && carry_r);
endmodule
bind or_stack_rotate_exec_unit or_stack_rotate_chk chk_i (.clock, .rst_b, .op_valid, .op_code,
  .src_bit, .op_ready, .accumulator_reg, .carry_r, .stack_pointer, .pc_load_r, .prio_release_r,
  .done_r);
`default_nettype wire

// File: sim/or_stack_rotate_exec_unit_test.sv
// Self-checking bench for the OR, stack and rotate execution unit
`timescale 1ns/10ps
`default_nettype none
`include "or_stack_rotate_map.vh"
module or_stack_rotate_exec_unit_test;
  logic clock = 0, rst_b = 0, op_valid = 0, dest_is_acc = 1, dest_is_port = 0, dest_is_sp = 0;
  logic src_bit = 0, op_ready, carry_r, pc_load_r, dwr_valid_r, prio_release_r, irq_hold_r, done_r;
  logic [`OP_W-1:0] op_code = `OP_NONE;
  logic [`SRC_W-1:0] src_sel = 2'h0;
  logic [7:0] direct_addr = 8'h30, bank_register = 8'h01, direct_data = 8'h02;
  logic [7:0] indirect_data = 8'h04, imm_data = 8'h08, port_latch = 8'h00;
  logic [7:0] accumulator_reg, stack_pointer, dwr_addr_r, dwr_data_r, probe_data;
  logic [15:0] program_counter;
  logic [3:0] release_count;
  integer err_total = 0, check_count = 0, cycles = 0, s;
  always #12.5 clock = ~clock;
  or_stack_rotate_exec_unit uut (.clock, .rst_b, .op_valid, .op_code, .src_sel, .dest_is_acc,
    .direct_addr, .bank_register, .direct_data, .indirect_data, .imm_data, .dest_is_port,
    .port_latch, .dest_is_sp, .src_bit, .op_ready, .accumulator_reg, .carry_r, .stack_pointer,
    .program_counter, .pc_load_r, .dwr_valid_r, .dwr_addr_r, .dwr_data_r, .prio_release_r,
    .irq_hold_r, .done_r);
  dmem_model dmem_i (.clock, .dwr_valid(dwr_valid_r), .dwr_addr(dwr_addr_r),
    .dwr_data(dwr_data_r), .prio_release(prio_release_r), .probe_addr(8'h30), .probe_data,
    .release_count);
  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      close_out;
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task do_reset;
    begin
      rst_b = 1'b0;
      repeat (16) @(posedge clock);
      #2 rst_b = 1'b1;
    end
  endtask
  // Returns in the cycle that done_r is seen, so pulses can be compared there
  task run(input logic [`OP_W-1:0] op);
    integer i;
    begin
      @(posedge clock);
      #2 op_code = op;
      op_valid = 1'b1;
      @(posedge clock);
      #2 op_valid = 1'b0;
      for (i = 0; i < 8 && done_r !== 1'b1; i = i + 1)
        @(posedge clock) #2;
    end
  endtask
  task t_or_byte;
    begin
      for (s = 0; s < 4; s = s + 1) begin
        src_sel = s[1:0];
        run(`OP_OR_BYTE);
        chk(accumulator_reg, (8'h02 << s) - 8'h01);
      end
      dest_is_acc = 1'b0;
      direct_data = 8'h50;
      src_sel = 2'h0;
      run(`OP_OR_BYTE);
      chk(dwr_valid_r, 1'b1);
      chk({dwr_addr_r, dwr_data_r}, 16'h305F);
      chk({carry_r, accumulator_reg}, 16'h000F);
      dest_is_port = 1'b1;
      port_latch = 8'hA0;
      direct_data = 8'h05;
      src_sel = 2'h3;
      run(`OP_OR_BYTE);
      chk(dwr_data_r, 8'hA8);
      @(posedge clock) #2;
      chk(probe_data, 8'hA8);
      $display("t_or_byte done");
    end
  endtask
  task t_carry;
    begin
      run(`OP_OR_CARRY);
      chk(carry_r, 1'b0);
      src_bit = 1'b1;
      run(`OP_OR_CARRY_INV);
      chk(carry_r, 1'b0);
      src_bit = 1'b0;
      run(`OP_OR_CARRY_INV);
      chk(carry_r, 1'b1);
      run(`OP_OR_CARRY);
      chk({carry_r, accumulator_reg}, 16'h010F);
      // Carry must start clear so a set source bit really moves it
      do_reset;
      src_bit = 1'b1;
      run(`OP_OR_CARRY);
      chk({carry_r, accumulator_reg}, 16'h0100);
      src_bit = 1'b0;
      $display("t_carry done");
    end
  endtask
  task t_rotate;
    begin
      do_reset;
      dest_is_acc = 1'b1;
      imm_data = 8'hC5;
      run(`OP_OR_BYTE);
      run(`OP_RL);
      chk({carry_r, accumulator_reg}, 16'h008B);
      run(`OP_RR);
      chk({carry_r, accumulator_reg}, 16'h00C5);
      run(`OP_RLC);
      chk({carry_r, accumulator_reg}, 16'h018A);
      run(`OP_RRC);
      chk({carry_r, accumulator_reg}, 16'h00C5);
      run(`OP_RRC);
      chk({carry_r, accumulator_reg}, 16'h0162);
      $display("t_rotate done");
    end
  endtask
  task t_stack;
    begin
      direct_data = 8'h23;
      run(`OP_PUSH);
      chk(stack_pointer, 8'h08);
      direct_data = 8'h01;
      run(`OP_PUSH);
      run(`OP_INTERRUPT_RETURN_OP);
      chk(program_counter, 16'h0123);
      chk({pc_load_r, irq_hold_r, stack_pointer}, 16'h0307);
      chk({carry_r, accumulator_reg}, 16'h0162);
      @(posedge clock) #2;
      chk(release_count, 4'h1);
      direct_data = 8'h20;
      run(`OP_PUSH);
      chk(irq_hold_r, 1'b1);
      @(posedge clock) #2;
      chk(irq_hold_r, 1'b0);
      dest_is_sp = 1'b1;
      run(`OP_POP);
      chk(stack_pointer, 8'h20);
      chk(dwr_valid_r, 1'b0);
      direct_data = 8'hFF;
      run(`OP_PUSH);
      run(`OP_POP);
      dest_is_sp = 1'b0;
      direct_data = 8'h5A;
      run(`OP_PUSH);
      chk(stack_pointer, 8'h00);
      direct_addr = 8'h44;
      run(`OP_POP);
      chk(dwr_valid_r, 1'b1);
      chk({dwr_addr_r, dwr_data_r}, 16'h445A);
      chk(stack_pointer, 8'hFF);
      $display("t_stack done");
    end
  endtask
  initial begin
    do_reset;
    t_or_byte;
    t_carry;
    t_rotate;
    t_stack;
    close_out;
  end
endmodule
`default_nettype wire

// File: src/exec_reg_ram.v
// Small internal data memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module exec_reg_ram #(
  parameter AW = 8,
  parameter DW = 8
) (
  input  wire          clock,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// File: src/or_stack_rotate_exec_unit.v
// Execution unit for byte/bit OR, push, pop, interrupt return and accumulator rotates
`timescale 1ns/10ps
`default_nettype none
`include "or_stack_rotate_map.vh"
module or_stack_rotate_exec_unit #(
  parameter DW = 8,
  parameter AW = 8
) (
  input  wire             clock,
  input  wire             rst_b,
  input  wire             op_valid,
  input  wire [`OP_W-1:0] op_code,
  input  wire [`SRC_W-1:0] src_sel,
  input  wire             dest_is_acc,
  input  wire [AW-1:0]    direct_addr,
  input  wire [DW-1:0]    bank_register,
  input  wire [DW-1:0]    direct_data,
  input  wire [DW-1:0]    indirect_data,
  input  wire [DW-1:0]    imm_data,
  input  wire             dest_is_port,
  input  wire [DW-1:0]    port_latch,
  input  wire             dest_is_sp,
  input  wire             src_bit,
  output wire             op_ready,
  output reg  [DW-1:0]    accumulator_reg,
  output reg              carry_r,
  output reg  [AW-1:0]    stack_pointer,
  output reg  [15:0]      program_counter,
  output reg              pc_load_r,
  output reg              dwr_valid_r,
  output reg  [AW-1:0]    dwr_addr_r,
  output reg  [DW-1:0]    dwr_data_r,
  output reg              prio_release_r,
  output reg              irq_hold_r,
  output reg              done_r
);
  reg  [2:0]    state_r;
  reg  [2:0]    state_nxt;
  reg  [`OP_W-1:0] op_r;
  reg  [DW-1:0] src_r;
  reg           to_sp_r;
  reg  [AW-1:0] dst_r;
  reg           irq_wait_r;
  reg           ram_we;
  reg  [AW-1:0] ram_waddr;
  reg  [DW-1:0] ram_wdata;
  reg  [AW-1:0] ram_raddr;
  wire [DW-1:0] ram_rdata;
  reg  [DW-1:0] or_src;
  wire [DW-1:0] dest_old;
  wire [AW-1:0] sp_dec;
  wire [AW-1:0] sp_inc;

  assign op_ready = (state_r == `ST_IDLE);
  assign sp_dec   = stack_pointer - `SP_ONE;
  assign sp_inc   = stack_pointer + `SP_ONE;
  // Port destinations use the latch so read-modify-write never sees pin loading
  assign dest_old = dest_is_port ? port_latch : direct_data;

  always @* begin
    case (src_sel)
      `SRC_BANK:     or_src = bank_register;
      `SRC_DIRECT:   or_src = direct_data;
      `SRC_INDIRECT: or_src = indirect_data;
      default:       or_src = imm_data;
    endcase
  end

  always @* begin
    ram_raddr = stack_pointer;
    ram_we    = 1'b0;
    ram_waddr = stack_pointer;
    ram_wdata = src_r;
    state_nxt = state_r;
    case (state_r)
      `ST_IDLE: begin
        if (op_valid && op_code == `OP_POP) begin
          state_nxt = `ST_RD;
        end else if (op_valid && op_code == `OP_PUSH) begin
          state_nxt = `ST_WR;
        end else if (op_valid && op_code == `OP_INTERRUPT_RETURN_OP) begin
          state_nxt = `ST_INTERRUPT_RETURN_OP_HI;
        end
      end
      `ST_RD: begin
        state_nxt = `ST_IDLE;
      end
      `ST_WR: begin
        ram_we    = 1'b1;
        state_nxt = `ST_IDLE;
      end
      `ST_INTERRUPT_RETURN_OP_HI: begin
        // Fetch the low byte one below while the pointer steps down
        ram_raddr = sp_dec;
        state_nxt = `ST_INTERRUPT_RETURN_OP_LO;
      end
      `ST_INTERRUPT_RETURN_OP_LO: begin
        state_nxt = `ST_DONE;
      end
      `ST_DONE: begin
        state_nxt = `ST_IDLE;
      end
      default: begin
        state_nxt = `ST_IDLE;
      end
    endcase
  end

  exec_reg_ram #(
    .AW (AW),
    .DW (DW)
  ) u_ram (
    .clock (clock),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (ram_wdata),
    .raddr (ram_raddr),
    .rdata (ram_rdata)
  );

  always @(posedge clock) begin
    if (!rst_b) begin
      state_r         <= `ST_IDLE;
      op_r            <= `OP_NONE;
      src_r           <= {DW{1'b0}};
      to_sp_r         <= 1'b0;
      dst_r           <= {AW{1'b0}};
      accumulator_reg <= `ACC_RESET;
      carry_r         <= 1'b0;
      stack_pointer   <= `SP_RESET;
      program_counter <= `PC_RESET;
      pc_load_r       <= 1'b0;
      dwr_valid_r     <= 1'b0;
      dwr_addr_r      <= {AW{1'b0}};
      dwr_data_r      <= {DW{1'b0}};
      prio_release_r  <= 1'b0;
      irq_hold_r      <= 1'b0;
      irq_wait_r      <= 1'b0;
      done_r          <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      pc_load_r      <= 1'b0;
      dwr_valid_r    <= 1'b0;
      prio_release_r <= 1'b0;
      done_r         <= 1'b0;
      // Interrupts of equal or lower level stay blocked through the next instruction
      if (irq_hold_r && done_r && !irq_wait_r) begin
        irq_hold_r <= 1'b0;
      end
      if (irq_wait_r && done_r) begin
        irq_wait_r <= 1'b0;
      end
      case (state_r)
        `ST_IDLE: begin
          if (op_valid) begin
            op_r    <= op_code;
            to_sp_r <= dest_is_sp;
            dst_r   <= direct_addr;
            src_r   <= direct_data;
            case (op_code)
              `OP_OR_BYTE: begin
                done_r <= 1'b1;
                if (dest_is_acc) begin
                  accumulator_reg <= accumulator_reg | or_src;
                end else begin
                  dwr_valid_r <= 1'b1;
                  dwr_addr_r  <= direct_addr;
                  // Direct destination takes accumulator or immediate only
                  dwr_data_r  <= dest_old | ((src_sel == `SRC_IMM) ? imm_data
                                                                    : accumulator_reg);
                end
              end
              `OP_OR_CARRY: begin
                done_r  <= 1'b1;
                carry_r <= carry_r | src_bit;
              end
              `OP_OR_CARRY_INV: begin
                done_r  <= 1'b1;
                carry_r <= carry_r | ~src_bit;
              end
              `OP_PUSH: begin
                stack_pointer <= sp_inc;
              end
              `OP_RL: begin
                done_r          <= 1'b1;
                accumulator_reg <= {accumulator_reg[DW-2:0], accumulator_reg[DW-1]};
              end
              `OP_RLC: begin
                done_r          <= 1'b1;
                accumulator_reg <= {accumulator_reg[DW-2:0], carry_r};
                carry_r         <= accumulator_reg[DW-1];
              end
              `OP_RR: begin
                done_r          <= 1'b1;
                accumulator_reg <= {accumulator_reg[0], accumulator_reg[DW-1:1]};
              end
              `OP_RRC: begin
                done_r          <= 1'b1;
                accumulator_reg <= {carry_r, accumulator_reg[DW-1:1]};
                carry_r         <= accumulator_reg[0];
              end
              default: begin
                done_r <= (op_code != `OP_NONE) && (op_code != `OP_POP)
                          && (op_code != `OP_INTERRUPT_RETURN_OP);
              end
            endcase
          end
        end
        `ST_RD: begin
          // Read data is valid now; decrement before the optional pointer overwrite
          done_r      <= 1'b1;
          dwr_valid_r <= ~to_sp_r;
          dwr_addr_r  <= dst_r;
          dwr_data_r  <= ram_rdata;
          stack_pointer <= to_sp_r ? ram_rdata : sp_dec;
        end
        `ST_WR: begin
          done_r <= 1'b1;
        end
        `ST_INTERRUPT_RETURN_OP_HI: begin
          program_counter[15:8] <= ram_rdata;
          stack_pointer         <= sp_dec;
        end
        `ST_INTERRUPT_RETURN_OP_LO: begin
          program_counter[7:0] <= ram_rdata;
          stack_pointer        <= sp_dec;
        end
        `ST_DONE: begin
          // Only counter and pointer changed; status word is left alone
          pc_load_r      <= 1'b1;
          prio_release_r <= 1'b1;
          irq_hold_r     <= `LOCK_INSNS;
          irq_wait_r     <= 1'b1;
          done_r         <= 1'b1;
        end
        default: begin
          done_r <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: src/or_stack_rotate_map.vh
// Operation codes, constants and timing for the OR, stack and rotate execution unit
`ifndef OR_STACK_ROTATE_MAP_VH
`define OR_STACK_ROTATE_MAP_VH
`define OP_W              4
`define OP_NONE           4'h0
`define OP_OR_BYTE        4'h1
`define OP_OR_CARRY       4'h2
`define OP_OR_CARRY_INV   4'h3
`define OP_POP            4'h4
`define OP_PUSH           4'h5
`define OP_INTERRUPT_RETURN_OP           4'h6
`define OP_RL             4'h7
`define OP_RLC            4'h8
`define OP_RR             4'h9
`define OP_RRC            4'hA
`define SRC_W             2
`define SRC_BANK          2'h0
`define SRC_DIRECT        2'h1
`define SRC_INDIRECT      2'h2
`define SRC_IMM           2'h3
`define SP_RESET          8'h07
`define ACC_RESET         8'h00
`define PC_RESET          16'h0000
`define SP_ONE            8'h01
`define ST_IDLE           3'h0
`define ST_RD             3'h1
`define ST_WR             3'h2
`define ST_INTERRUPT_RETURN_OP_HI        3'h3
`define ST_INTERRUPT_RETURN_OP_LO        3'h4
`define ST_DONE           3'h5
`define LOCK_INSNS        1'b1
`endif
